// file: common/counter_pkg.sv
// Contract
// - every counter bit is a flop on the one shared clock edge
// - four-bit counter runs modulo 16, counts only with gate, clears on reset
// - load select makes each bit take its load bit, whatever the gate says
// - without load, bit n toggles only when gate and all lower bits are high
// - ten-bit lookahead counter uses gate-and-bits-0..2 and bits-3..6 group terms
// - up/down bit toggles on all-lower-high going up or all-lower-low going down
// - up/down bit 0 inverts every clock; first up term is up and bits 0,1 high
// - up/down bit 1 toggles on up with bit 0 high or down with bit 0 low
// - up/down bit 2 toggles when first up term or first down term is true
// - each further chain term is previous term ANDed with next bit high or low
// - bit k toggles on bit k-1 high with up term, or low with down term
// - initialization reset clears every counter register
// - active-high synchronous clear and load; clear beats load, load beats counting
package counter_pkg;

	// register byte addresses, one aligned word each
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] LOAD_OFS = 8'h04;
	localparam logic [7:0] BASIC_OFS = 8'h08;
	localparam logic [7:0] LOADABLE_OFS = 8'h0c;
	localparam logic [7:0] LOOKAHEAD_OFS = 8'h10;
	localparam logic [7:0] UPDOWN_OFS = 8'h14;

	// control register fields
	localparam int unsigned CTRL_GATE_BIT = 0;
	localparam int unsigned CTRL_UP_BIT = 1;
	localparam int unsigned CTRL_LOAD_BIT = 2;
	localparam int unsigned CTRL_CLEAR_BIT = 3;
	localparam int unsigned CTRL_W = 4;
	localparam logic [3:0] CTRL_RST = 4'h0;

	// counter widths and the load register
	localparam int unsigned BASIC_W = 4;
	localparam int unsigned LOADABLE_W = 8;
	localparam int unsigned LOOKAHEAD_W = 10;
	localparam int unsigned UPDOWN_W = 6;
	localparam int unsigned LOAD_W = 8;
	localparam logic [7:0] LOAD_RST = 8'h00;

	// serial carry: bit k toggles when the gate and every lower bit are high
	function automatic logic [9:0] rippleToggle(input logic [9:0] q, input logic gate);
		logic [9:0] tog;
		tog = 10'h000;
		tog[0] = gate;
		for (int k = 1; k < 10; k++) begin
			tog[k] = tog[k-1] & q[k-1];
		end
		return tog;
	endfunction : rippleToggle

endpackage : counter_pkg

// file: hdl/updown_counter.sv
`timescale 1ns/1ps
// six-bit ripple-carry up/down counter with synchronous clear and load
module updown_counter (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic load,
	input wire logic dirUp,
	input wire logic [5:0] loadValue,
	output logic [5:0] count
);

	logic [5:0] count_nxt;
	logic [5:0] toggle;
	logic [5:0] upChain;
	logic [5:0] downChain;
	logic firstUpChainTerm;
	logic firstDownChainTerm;
	logic secondUpChainTerm;
	logic secondDownChainTerm;

	// first chain terms look at the two lowest bits
	assign firstUpChainTerm = dirUp & count[0] & count[1];
	assign firstDownChainTerm = ~dirUp & ~count[0] & ~count[1];
	assign secondUpChainTerm = firstUpChainTerm & count[2];
	assign secondDownChainTerm = firstDownChainTerm & ~count[2];

	// chain grows one bit per stage; slow for wide counters but one term per bit
	always_comb begin
		upChain = 6'h00;
		downChain = 6'h00;
		toggle = 6'h00;
		toggle[0] = 1'b1;
		toggle[1] = (dirUp & count[0]) | (~dirUp & ~count[0]);
		upChain[2] = firstUpChainTerm;
		downChain[2] = firstDownChainTerm;
		toggle[2] = firstUpChainTerm | firstDownChainTerm;
		upChain[3] = secondUpChainTerm;
		downChain[3] = secondDownChainTerm;
		for (int k = 4; k < 6; k++) begin
			upChain[k] = upChain[k-1] & count[k-1];
			downChain[k] = downChain[k-1] & ~count[k-1];
		end
		for (int k = 3; k < 6; k++) begin
			// bit k-1 picks which chain counts, giving overall
			toggle[k] = (count[k-1] & upChain[k-1]) | (~count[k-1] & downChain[k-1]);
		end
	end

	// clear beats load, load beats counting; wrap falls out of the toggles
	assign count_nxt = clear ? 6'h00 : (load ? loadValue : (count ^ toggle));

	// all bits on the same edge, async reset only at initialization
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 6'h00;
		end else begin
			count <= count_nxt;
		end
	end

	// reset is sampled in the antecedent as well: on the edge that releases it
	// the flops are still held, so no step is owed one cycle later
	a_bit0_invert: assert property (@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !clear && !load) |=> (count[0] != $past(count[0])))
		else $error("up/down bit 0 did not invert");

	a_bit1_rule: assert property (@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !clear && !load && (dirUp == count[0])) |=> (count[1] != $past(count[1])))
		else $error("up/down bit 1 did not toggle");

	a_up_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !clear && !load && dirUp) |=> (count == $past(count) + 6'h01))
		else $error("up/down counter did not step up by one");

	a_down_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(!sys_rst && !clear && !load && !dirUp) |=> (count == $past(count) - 6'h01))
		else $error("up/down counter did not step down by one");

	a_clear_wins: assert property (@(posedge mclk) disable iff (sys_rst)
		clear |=> (count == 6'h00))
		else $error("up/down counter not cleared");

	a_load_takes: assert property (@(posedge mclk) disable iff (sys_rst)
		(!clear && load) |=> (count == $past(loadValue)))
		else $error("up/down counter did not load");

	c_down_wrap: cover property (@(posedge mclk) disable iff (sys_rst)
		(count == 6'h00 && !dirUp && !clear && !load) ##1 (count == 6'h3f));

endmodule : updown_counter

// file: hdl/counter_bank.sv
`timescale 1ns/1ps
// bank of synchronous binary counters behind a classic Wishbone slave
module counter_bank (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [3:0] count4,
	output logic [7:0] countLoad,
	output logic [9:0] count10,
	output logic [5:0] countUpDown
);

	logic ack_r;
	logic [31:0] datOut_r;
	logic [3:0] ctrl_r;
	logic [3:0] ctrl_nxt;
	logic [7:0] loadValue_r;
	logic [7:0] loadValue_nxt;
	logic [3:0] count4_r;
	logic [3:0] count4_nxt;
	logic [7:0] countLoad_r;
	logic [7:0] countLoad_nxt;
	logic [9:0] count10_r;
	logic [9:0] count10_nxt;
	logic [5:0] upDownValue;

	// bus decode; ack is held off one cycle so each request is taken once
	logic busReq;
	logic [7:0] wordAdr;
	logic hitCtrl;
	logic hitLoad;
	logic hitBasic;
	logic hitLoadable;
	logic hitLookahead;
	logic hitUpDown;
	logic wrCtrl;
	logic wrLoad;
	logic [31:0] readData;

	assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wordAdr = {wb_adr_i[7:2], 2'h0};
	assign hitCtrl = (wordAdr == counter_pkg::CTRL_OFS);
	assign hitLoad = (wordAdr == counter_pkg::LOAD_OFS);
	assign hitBasic = (wordAdr == counter_pkg::BASIC_OFS);
	assign hitLoadable = (wordAdr == counter_pkg::LOADABLE_OFS);
	assign hitLookahead = (wordAdr == counter_pkg::LOOKAHEAD_OFS);
	assign hitUpDown = (wordAdr == counter_pkg::UPDOWN_OFS);
	assign wrCtrl = busReq & wb_we_i & hitCtrl & wb_sel_i[0];
	assign wrLoad = busReq & wb_we_i & hitLoad & wb_sel_i[0];

	// read mux; unmapped words read as zero and still get an ack
	assign readData = hitCtrl ? {28'h000_0000, ctrl_r} :
		hitLoad ? {24'h00_0000, loadValue_r} :
		hitBasic ? {28'h000_0000, count4_r} :
		hitLoadable ? {24'h00_0000, countLoad_r} :
		hitLookahead ? {22'h00_0000, count10_r} :
		hitUpDown ? {26'h000_0000, upDownValue} :
		32'h0000_0000;

	// only byte lane 0 carries writable bits
	assign ctrl_nxt = wrCtrl ? wb_dat_i[3:0] : ctrl_r;
	assign loadValue_nxt = wrLoad ? wb_dat_i[7:0] : loadValue_r;

	// bus-side flops
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
			datOut_r <= 32'h0000_0000;
			ctrl_r <= counter_pkg::CTRL_RST;
			loadValue_r <= counter_pkg::LOAD_RST;
		end else begin
			ack_r <= busReq;
			datOut_r <= busReq ? readData : 32'h0000_0000;
			ctrl_r <= ctrl_nxt;
			loadValue_r <= loadValue_nxt;
		end
	end

	// control fields that steer the counters
	logic countGate;
	logic dirUp;
	logic loadSelect;
	logic syncClear;

	assign countGate = ctrl_r[counter_pkg::CTRL_GATE_BIT];
	assign dirUp = ctrl_r[counter_pkg::CTRL_UP_BIT];
	assign loadSelect = ctrl_r[counter_pkg::CTRL_LOAD_BIT];
	assign syncClear = ctrl_r[counter_pkg::CTRL_CLEAR_BIT];

	// four-bit ripple-carry counter with gate and clear
	logic [9:0] basicTogFull;
	logic [3:0] basicTog;

	assign basicTogFull = counter_pkg::rippleToggle({6'h00, count4_r}, countGate);
	assign basicTog = basicTogFull[3:0];
	assign count4_nxt = syncClear ? 4'h0 : (count4_r ^ basicTog);

	// eight-bit counter with parallel load; load overrides the gate entirely
	logic [9:0] loadTogFull;
	logic [7:0] loadTog;
	logic loadGate;

	assign loadGate = countGate & ~loadSelect;
	assign loadTogFull = counter_pkg::rippleToggle({2'h0, countLoad_r}, loadGate);
	assign loadTog = loadTogFull[7:0];
	assign countLoad_nxt = syncClear ? 8'h00 :
		(loadSelect ? loadValue_r : (countLoad_r ^ loadTog));

	// ten-bit lookahead counter: wide group terms replace the serial chain
	// so the upper bits see at most four gate levels, at the cost of fan-out
	logic lowGroupCarry;
	logic midLowAllHigh;
	logic midGroupAllHigh;
	logic upperGroupAllHigh;
	logic [9:0] lookTog;

	assign lowGroupCarry = count10_r[0] & count10_r[1] & count10_r[2] & countGate;
	assign midLowAllHigh = count10_r[3] & count10_r[4] & count10_r[5];
	assign midGroupAllHigh = midLowAllHigh & count10_r[6];
	assign upperGroupAllHigh = midGroupAllHigh & count10_r[7] & count10_r[8];
	assign lookTog[0] = countGate;
	assign lookTog[1] = countGate & count10_r[0];
	assign lookTog[2] = countGate & count10_r[0] & count10_r[1];
	assign lookTog[3] = lowGroupCarry;
	assign lookTog[4] = lowGroupCarry & count10_r[3];
	assign lookTog[5] = lowGroupCarry & count10_r[3] & count10_r[4];
	assign lookTog[6] = lowGroupCarry & midLowAllHigh;
	assign lookTog[7] = lowGroupCarry & midGroupAllHigh;
	assign lookTog[8] = lowGroupCarry & midGroupAllHigh & count10_r[7];
	assign lookTog[9] = lowGroupCarry & upperGroupAllHigh;
	assign count10_nxt = syncClear ? 10'h000 : (count10_r ^ lookTog);

	// every counter bit on the same edge; no stage clocks another
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count4_r <= 4'h0;
			countLoad_r <= 8'h00;
			count10_r <= 10'h000;
		end else begin
			count4_r <= count4_nxt;
			countLoad_r <= countLoad_nxt;
			count10_r <= count10_nxt;
		end
	end

	// up/down counter free-runs in the direction set by software
	updown_counter u_updown (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clear(syncClear),
		.load(loadSelect),
		.dirUp(dirUp),
		.loadValue(loadValue_r[5:0]),
		.count(upDownValue)
	);

	// outputs straight from flops
	assign wb_ack_o = ack_r;
	assign wb_dat_o = datOut_r;
	assign count4 = count4_r;
	assign countLoad = countLoad_r;
	assign count10 = count10_r;
	assign countUpDown = upDownValue;

	a_gate_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(!countGate && !syncClear) |=> $stable(count4_r))
		else $error("basic counter moved with gate low");

	a_basic_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(countGate && !syncClear) |=> (count4_r == $past(count4_r) + 4'h1))
		else $error("basic counter did not step by one");

	a_basic_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		syncClear |=> (count4_r == 4'h0 && countLoad_r == 8'h00 && count10_r == 10'h000))
		else $error("synchronous clear missed a counter");

	a_load_priority: assert property (@(posedge mclk) disable iff (sys_rst)
		(loadSelect && !syncClear) |=> (countLoad_r == $past(loadValue_r)))
		else $error("loadable counter did not take load value");

	a_loadable_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(countGate && !loadSelect && !syncClear) |=> (countLoad_r == $past(countLoad_r) + 8'h01))
		else $error("loadable counter did not step by one");

	a_lookahead_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(countGate && !syncClear) |=> (count10_r == $past(count10_r) + 10'h001))
		else $error("lookahead counter did not step by one");

	a_lookahead_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
		(count10_r == 10'h3ff && countGate && !syncClear) |=> (count10_r == 10'h000))
		else $error("lookahead counter did not wrap");

	a_ack_single: assert property (@(posedge mclk) disable iff (sys_rst)
		(wb_cyc_i && wb_stb_i && !ack_r) |=> (ack_r ##1 !ack_r))
		else $error("ack not a single cycle pulse");

	// bus side: the answer is registered, so ack and data only follow a taken request
	a_ack_follows: assert property (@(posedge mclk) disable iff (sys_rst)
		busReq |=> ack_r)
		else $error("taken request got no ack");

	a_ack_spurious: assert property (@(posedge mclk) disable iff (sys_rst)
		!busReq |=> !ack_r)
		else $error("ack without a taken request");

	a_data_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
		!ack_r |-> (datOut_r == 32'h0000_0000))
		else $error("read data not zero outside ack");

	// writable fields change only through a lane-0 write to their own word
	a_ctrl_write: assert property (@(posedge mclk) disable iff (sys_rst)
		wrCtrl |=> (ctrl_r == $past(wb_dat_i[3:0])))
		else $error("control write not taken");

	a_ctrl_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!wrCtrl |=> $stable(ctrl_r))
		else $error("control changed without a write");

	a_loadreg_write: assert property (@(posedge mclk) disable iff (sys_rst)
		wrLoad |=> (loadValue_r == $past(wb_dat_i[7:0])))
		else $error("load value write not taken");

	a_loadreg_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!wrLoad |=> $stable(loadValue_r))
		else $error("load value changed without a write");

	a_lane_gate: assert property (@(posedge mclk) disable iff (sys_rst)
		(busReq && wb_we_i && !wb_sel_i[0]) |=> ($stable(ctrl_r) && $stable(loadValue_r)))
		else $error("write without lane 0 changed a register");

	a_readonly_drop: assert property (@(posedge mclk) disable iff (sys_rst)
		(busReq && wb_we_i && !hitCtrl && !hitLoad) |=> ($stable(ctrl_r) && $stable(loadValue_r)))
		else $error("read-only or unmapped write changed a register");

	// counters: a closed gate freezes them, and a full count rolls over to zero
	a_basic_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
		(count4_r == 4'hf && countGate && !syncClear) |=> (count4_r == 4'h0))
		else $error("basic counter did not wrap");

	a_basic_top: assert property (@(posedge mclk) disable iff (sys_rst)
		(!syncClear && !(countGate && count4_r[2:0] == 3'h7)) |=> (count4_r[3] == $past(count4_r[3])))
		else $error("basic counter top bit moved without a carry");

	a_loadable_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(!countGate && !loadSelect && !syncClear) |=> $stable(countLoad_r))
		else $error("loadable counter moved with gate low");

	a_loadable_lsb: assert property (@(posedge mclk) disable iff (sys_rst)
		(countGate && !loadSelect && !syncClear) |=> (countLoad_r[0] != $past(countLoad_r[0])))
		else $error("loadable counter bit 0 did not toggle");

	a_loadable_msb: assert property (@(posedge mclk) disable iff (sys_rst)
		(countGate && !loadSelect && !syncClear && countLoad_r[6:0] != 7'h7f)
		|=> (countLoad_r[7] == $past(countLoad_r[7])))
		else $error("loadable counter top bit moved without a carry");

	a_loadable_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
		(countLoad_r == 8'hff && countGate && !loadSelect && !syncClear) |=> (countLoad_r == 8'h00))
		else $error("loadable counter did not wrap");

	a_clear_over_load: assert property (@(posedge mclk) disable iff (sys_rst)
		(syncClear && loadSelect) |=> (countLoad_r == 8'h00))
		else $error("load won over clear");

	// upper lookahead bits must move only on the group carry
	a_lookahead_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(!countGate && !syncClear) |=> $stable(count10_r))
		else $error("lookahead counter moved with gate low");

	a_group_carry: assert property (@(posedge mclk) disable iff (sys_rst)
		(countGate && !syncClear && count10_r[6:0] == 7'h7f) |=> (count10_r[7] != $past(count10_r[7])))
		else $error("lookahead bit 7 missed the group carry");

	a_upper_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(!syncClear && !(countGate && count10_r[6:0] == 7'h7f))
		|=> (count10_r[9:7] == $past(count10_r[9:7])))
		else $error("lookahead upper bits moved without the group carry");

	// the up/down counter shares the clear with the rest of the bank
	a_updown_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		syncClear |=> (upDownValue == 6'h00))
		else $error("up/down counter missed the clear");

	c_lookahead_wrap: cover property (@(posedge mclk) disable iff (sys_rst)
		(count10_r == 10'h3ff) ##1 (count10_r == 10'h000));

	c_ctrl_write: cover property (@(posedge mclk) disable iff (sys_rst)
		wrCtrl ##1 ack_r);

	c_load_then_count: cover property (@(posedge mclk) disable iff (sys_rst)
		(loadSelect && countGate) ##1 (!loadSelect && countGate));

	c_basic_wrap: cover property (@(posedge mclk) disable iff (sys_rst)
		(count4_r == 4'hf && countGate) ##1 (count4_r == 4'h0));

endmodule : counter_bank

// file: testbench/wb_master.sv
`timescale 1ns/1ps
// classic single-cycle bus master standing in for the user logic that drives the counters
module wb_master (
	input wire logic mclk,
	input wire logic ack,
	input wire logic [31:0] rdData,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] wrData
);
	// idle bus at time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wrData = 32'h0000_0000;
	end

	// one transfer, entered just after a rising edge; request held until ack is sampled
	task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		sel <= s;
		wrData <= d;
		@(posedge mclk);
		while (ack !== 1'b1) @(posedge mclk);
		q = rdData;
		cyc <= 1'b0;
		stb <= 1'b0;
		// released data lines flip rather than keep a stale copy
		wrData <= ~d;
		@(posedge mclk);
	endtask : access
endmodule : wb_master

// file: testbench/tb.sv
`timescale 1ns/1ps
// self-checking bench: a cycle model of the counters predicts every counter port and every read
module tb;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	logic [3:0] count4, mCtrl, m4;
	logic [7:0] countLoad, mLoad, mL;
	logic [9:0] count10, m10;
	logic [5:0] countUpDown, mU;
	logic [31:0] expQ[$];
	int miscompares = 0;
	int compares = 0;
	int n;

	always #5 mclk = ~mclk;

	counter_bank counter_bank_inst (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .count4(count4), .countLoad(countLoad),
		.count10(count10), .countUpDown(countUpDown));
	wb_master wb_master_inst (.mclk(mclk), .ack(ack), .rdData(rdat), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .wrData(wdat));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [31:0] regVal(input logic [7:0] a);
		case ({a[7:2], 2'b00})
			counter_pkg::CTRL_OFS: return {28'h000_0000, mCtrl};
			counter_pkg::LOAD_OFS: return {24'h00_0000, mLoad};
			counter_pkg::BASIC_OFS: return {28'h000_0000, m4};
			counter_pkg::LOADABLE_OFS: return {24'h00_0000, mL};
			counter_pkg::LOOKAHEAD_OFS: return {22'h00_0000, m10};
			counter_pkg::UPDOWN_OFS: return {26'h000_0000, mU};
			default: return 32'h0000_0000;
		endcase
	endfunction : regVal

	// cycle model: compare ports with pre-edge state, note reads, then advance
	always @(posedge mclk) begin
		if (sys_rst) begin
			{mCtrl, mLoad, m4, mL, m10, mU} = '0;
		end else begin
			check({4'h0, count4, countLoad, count10, countUpDown}, {4'h0, m4, mL, m10, mU});
			if (cyc && stb && !ack && !we) expQ.push_back(regVal(adr));
			if (mCtrl[counter_pkg::CTRL_CLEAR_BIT]) begin
				{m4, mL, m10, mU} = '0;
			end else begin
				if (mCtrl[counter_pkg::CTRL_GATE_BIT]) begin
					m4 = m4 + 4'h1;
					m10 = m10 + 10'h001;
				end
				if (mCtrl[counter_pkg::CTRL_LOAD_BIT]) begin
					mL = mLoad;
					mU = mLoad[5:0];
				end else begin
					mL = mL + {7'h00, mCtrl[counter_pkg::CTRL_GATE_BIT]};
					mU = mCtrl[counter_pkg::CTRL_UP_BIT] ? mU + 6'h01 : mU - 6'h01;
				end
			end
			// only lane 0 carries writable bits; other places drop writes
			if (cyc && stb && !ack && we && sel[0]) begin
				if ({adr[7:2], 2'b00} == counter_pkg::CTRL_OFS) mCtrl = wdat[3:0];
				if ({adr[7:2], 2'b00} == counter_pkg::LOAD_OFS) mLoad = wdat[7:0];
			end
		end
	end

	// read checker: each read answer takes the oldest note
	always @(posedge mclk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			check(rdat, expQ.size() > 0 ? expQ.pop_front() : 32'hxxxx_xxxx);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_master_inst.access(1'b1, a, 4'h1, d, rd);
	endtask : wr

	task automatic wrCtrl(input logic g, input logic u, input logic l, input logic c);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[counter_pkg::CTRL_GATE_BIT] = g;
		v[counter_pkg::CTRL_UP_BIT] = u;
		v[counter_pkg::CTRL_LOAD_BIT] = l;
		v[counter_pkg::CTRL_CLEAR_BIT] = c;
		wr(counter_pkg::CTRL_OFS, v);
	endtask : wrCtrl

	// sweeps two unmapped words too
	task automatic readAll;
		for (int i = 0; i < 8; i++) wb_master_inst.access(1'b0, 8'(i * 4), 4'hf, 32'h0000_0000, rd);
	endtask : readAll

	task automatic end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		n = $urandom(24);
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		readAll();
		// unmapped, read-only and lane-gated writes change nothing
		wr(8'h18, $urandom());
		wr(counter_pkg::BASIC_OFS, 32'hffff_ffff);
		wb_master_inst.access(1'b1, counter_pkg::CTRL_OFS, 4'he, 32'h0000_000f, rd);
		readAll();
		wrCtrl(1'b1, 1'b1, 1'b0, 1'b0);
		repeat (1100) @(posedge mclk);
		readAll();
		// load wins over a closed gate, then both directions wrap
		wr(counter_pkg::LOAD_OFS, 32'h0000_00ff);
		wrCtrl(1'b0, 1'b1, 1'b1, 1'b0);
		readAll();
		wrCtrl(1'b0, 1'b1, 1'b0, 1'b0);
		readAll();
		wr(counter_pkg::LOAD_OFS, 32'h0000_0000);
		wrCtrl(1'b1, 1'b0, 1'b1, 1'b0);
		wrCtrl(1'b1, 1'b0, 1'b0, 1'b0);
		readAll();
		wrCtrl(1'b1, 1'b1, 1'b1, 1'b1);
		readAll();
		// random traffic with random idle gaps
		for (int i = 0; i < 80; i++) begin
			n = $urandom_range(0, 3);
			if (n == 0) wr(counter_pkg::CTRL_OFS, $urandom_range(0, 15));
			else if (n == 1) wr(counter_pkg::LOAD_OFS, $urandom());
			else wb_master_inst.access(1'b0, 8'($urandom_range(0, 31)), 4'hf, 32'h0000_0000, rd);
			repeat ($urandom_range(0, 3)) @(posedge mclk);
		end
		// second reset in mid-run
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		readAll();
		end_of_test();
	end

	// watchdog sized far beyond the under two thousand cycles the sequence needs
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		$display("Error at %0t: timeout", $time);
		end_of_test();
	end
endmodule : tb
